// ---- core/fhc_flash_host.sv ----
`timescale 1ns/10ps
`include "fhc_map.svh"
module fhc_flash_host #(
	parameter int unsigned INIT_PULSE_CYC  = `FHC_CYC_UP(`FHC_INIT_PULSE_NS),
	parameter int unsigned READY_BUSY_CYC  = 16'd5000,
	parameter int unsigned SLEEP_CYC       =
		`FHC_CYC_UP(`FHC_ADDR_ACCESS_NS + `FHC_SLEEP_EXTRA_NS)
) (
	input  wire logic               clock,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	input  wire logic               req_valid,
	input  wire logic               req_write,
	input  wire logic               req_init,
	input  wire logic               req_byte_mode,
	input  wire logic [20:0]        req_addr,
	input  wire logic [15:0]        req_wdata,
	input  wire logic [15:0]        dq_in,
	input  wire logic               ready_busy_n,
	output fhc_pkg::fhc_pins_type   pins,
	output logic [15:0]             rdata,
	output logic                    rvalid,
	output logic                    done,
	output logic                    busy,
	output logic [5:0]              sector_index,
	output logic                    restart_needed
);
	localparam logic [15:0] READ_CYC  = 16'(`FHC_CYC_UP(`FHC_SELECT_ACCESS_NS));
	localparam logic [15:0] WRITE_CYC = 16'(`FHC_CYC_UP(`FHC_WRITE_PULSE_NS));
	localparam logic [15:0] RECOV_CYC = 16'(`FHC_CYC_UP(`FHC_INIT_RECOVERY_NS));
	localparam logic [15:0] PULSE_CYC = 16'(INIT_PULSE_CYC);
	localparam logic [15:0] RB_CYC    = 16'(READY_BUSY_CYC);

	fhc_pkg::fhc_regs_type r_reg;
	fhc_pkg::fhc_regs_type r_next;

	// counter step shared by every timed state
	function automatic logic [15:0] cnt_step(input logic [15:0] c);
		return c + 16'h0001;
	endfunction

	// true once the next count reaches the limit
	function automatic logic cnt_hit(input logic [15:0] c, input logic [15:0] lim);
		return cnt_step(c) >= lim;
	endfunction

	// top boot sector decode from word address bits 19..12
	function automatic logic [5:0] top_sector(input logic [19:0] wa);
		logic [5:0] s;
		s = {1'b0, wa[19:15]};
		if (wa[19:13] == 7'h7F)
			s = `FHC_SECTOR_34;
		else if (wa[19:14] == 6'h3F)
			s = wa[12] ? `FHC_SECTOR_33 : `FHC_SECTOR_32;
		else if (wa[19:15] == `FHC_TOP_SECTOR_BASE)
			s = `FHC_SECTOR_31;
		return s;
	endfunction

	always_comb
	begin
		r_next = r_reg;
		r_next.rvalid = 1'b0;
		r_next.done = 1'b0;
		unique case (r_reg.state)
			fhc_pkg::st_idle:
			begin
				r_next.busy = 1'b0;
				r_next.pins.sel_n = 1'b1;
				r_next.pins.oe_n = 1'b1;
				r_next.pins.we_n = 1'b1;
				r_next.pins.dq_oe_n = 1'b1;
				if (req_valid)
				begin
					r_next.busy = 1'b1;
					r_next.cnt = 16'h0000;
					// byte mode address lsb on addr bit 0
					r_next.pins.byte_n = ~req_byte_mode;
					r_next.pins.addr = req_addr;
					r_next.sector = top_sector(req_byte_mode ? req_addr[20:1] : req_addr[19:0]);
					if (req_init)
					begin
						r_next.pins.init_n = 1'b0;
						r_next.state = fhc_pkg::st_init_pulse;
					end
					else if (req_write)
					begin
						r_next.pins.sel_n = 1'b0;
						r_next.pins.we_n = 1'b0;
						// upper lane idle in byte mode
						if (req_byte_mode)
						begin
							r_next.pins.dq_out = {8'h00, req_wdata[7:0]};
						end
						else
						begin
							r_next.pins.dq_out = req_wdata;
						end
						r_next.pins.dq_oe_n = 1'b0;
						r_next.state = fhc_pkg::st_write;
					end
					else
					begin
						r_next.pins.sel_n = 1'b0;
						r_next.pins.oe_n = 1'b0;
						r_next.state = fhc_pkg::st_read;
					end
				end
			end
			fhc_pkg::st_read:
			begin
				r_next.cnt = cnt_step(r_reg.cnt);
				if (cnt_hit(r_reg.cnt, READ_CYC))
				begin
					// status or array on low lane
					if (r_reg.pins.byte_n)
					begin
						r_next.rdata = dq_in;
					end
					else
					begin
						r_next.rdata = {8'h00, dq_in[7:0]};
					end
					r_next.rvalid = 1'b1;
					r_next.done = 1'b1;
					r_next.state = fhc_pkg::st_idle;
					r_next.pins.oe_n = 1'b1;
					r_next.pins.sel_n = 1'b1;
				end
			end
			fhc_pkg::st_write:
			begin
				r_next.cnt = cnt_step(r_reg.cnt);
				if (cnt_hit(r_reg.cnt, WRITE_CYC))
				begin
					r_next.pins.we_n = 1'b1;
					r_next.state = fhc_pkg::st_write_hold;
				end
			end
			fhc_pkg::st_write_hold:
			begin
				r_next.pins.sel_n = 1'b1;
				r_next.pins.dq_oe_n = 1'b1;
				r_next.restart_needed = 1'b0;
				r_next.done = 1'b1;
				r_next.state = fhc_pkg::st_idle;
			end
			fhc_pkg::st_init_pulse:
			begin
				r_next.cnt = cnt_step(r_reg.cnt);
				r_next.pins.sel_n = 1'b1;
				r_next.pins.oe_n = 1'b1;
				r_next.pins.we_n = 1'b1;
				r_next.pins.dq_oe_n = 1'b1;
				if (!ready_busy_n)
					r_next.restart_needed = 1'b1;
				if (cnt_hit(r_reg.cnt, PULSE_CYC))
				begin
					r_next.pins.init_n = 1'b1;
					r_next.cnt = 16'h0000;
					r_next.state = fhc_pkg::st_init_wait;
				end
			end
			fhc_pkg::st_init_wait:
			begin
				r_next.cnt = cnt_step(r_reg.cnt);
				if (cnt_hit(r_reg.cnt, RB_CYC))
				begin
					r_next.done = 1'b1;
					r_next.state = fhc_pkg::st_idle;
				end
				else if (ready_busy_n && cnt_hit(r_reg.cnt, RECOV_CYC))
				begin
					r_next.done = 1'b1;
					r_next.state = fhc_pkg::st_idle;
				end
			end
			default:
				r_next.state = fhc_pkg::st_idle;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			r_reg <= '0;
			r_reg.state <= fhc_pkg::st_idle;
			r_reg.pins.sel_n <= 1'b1;
			r_reg.pins.oe_n <= 1'b1;
			r_reg.pins.we_n <= 1'b1;
			r_reg.pins.init_n <= 1'b1;
			r_reg.pins.byte_n <= 1'b1;
			r_reg.pins.dq_oe_n <= 1'b1;
		end
		else if (clk_en)
			r_reg <= r_next;
	end

	assign pins = r_reg.pins;
	assign rdata = r_reg.rdata;
	assign rvalid = r_reg.rvalid;
	assign done = r_reg.done;
	assign busy = r_reg.busy;
	assign sector_index = r_reg.sector;
	assign restart_needed = r_reg.restart_needed;
endmodule

// ---- core/fhc_map.svh ----
`ifndef FHC_MAP_SVH
`define FHC_MAP_SVH
`define FHC_CLK_MHZ          25
`define FHC_ADDR_ACCESS_NS   70
`define FHC_SELECT_ACCESS_NS 70
`define FHC_OE_ACCESS_NS     30
`define FHC_WRITE_PULSE_NS   35
`define FHC_INIT_PULSE_NS    500
`define FHC_INIT_RECOVERY_NS 50
`define FHC_SLEEP_EXTRA_NS   30
`define FHC_CYC_UP(ns)       ((((ns) * `FHC_CLK_MHZ) + 999) / 1000)
`define FHC_TOP_SECTOR_BASE  5'h1F
`define FHC_SECTOR_31        6'h1F
`define FHC_SECTOR_32        6'h20
`define FHC_SECTOR_33        6'h21
`define FHC_SECTOR_34        6'h22
`define FHC_CNT_W            16
`endif

// ---- core/fhc_pkg.sv ----
package fhc_pkg;
	typedef enum logic [2:0] {
		st_idle,
		st_read,
		st_write,
		st_write_hold,
		st_init_pulse,
		st_init_wait
	} fhc_state_type;

	typedef struct packed {
		logic        sel_n;
		logic        oe_n;
		logic        we_n;
		logic        init_n;
		logic        byte_n;
		logic [20:0] addr;
		logic [15:0] dq_out;
		logic        dq_oe_n;
	} fhc_pins_type;

	typedef struct packed {
		fhc_state_type   state;
		logic [15:0]     cnt;
		fhc_pins_type    pins;
		logic [15:0]     rdata;
		logic            rvalid;
		logic            done;
		logic            busy;
		logic [5:0]      sector;
		logic            restart_needed;
	} fhc_regs_type;
endpackage

// ---- sim/fhc_flash_host_sva.sv ----
`timescale 1ns/10ps
module fhc_flash_host_sva (
	input wire logic             clock,
	input wire logic             rst_n,
	input wire logic             clk_en,
	input wire logic             req_valid,
	input wire logic             req_write,
	input wire logic             req_init,
	input fhc_pkg::fhc_pins_type pins,
	input wire logic             rvalid,
	input wire logic             done,
	input wire logic             busy
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic take;
	assign take = clk_en && req_valid && !busy && !req_init;
	property p_rd_pins;
		!pins.oe_n |-> !pins.sel_n && pins.we_n && pins.dq_oe_n;
	endproperty
	a_rd_pins: assert property (p_rd_pins) else $error("read pins");
	property p_wr_pins;
		!pins.we_n |-> !pins.sel_n && pins.oe_n && !pins.dq_oe_n;
	endproperty
	a_wr_pins: assert property (p_wr_pins) else $error("write pins");
	property p_rd_lat;
		take && !req_write |-> ##3 rvalid && done;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read latency");
	property p_wr_lat;
		take && req_write |=> !pins.we_n ##1 pins.we_n ##1 done;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write pulse");
	property p_init_w;
		$fell(pins.init_n) |-> !pins.init_n [*8];
	endproperty
	a_init_w: assert property (p_init_w) else $error("init width");
	property p_init_rec;
		$rose(pins.init_n) |-> pins.oe_n [*2];
	endproperty
	a_init_rec: assert property (p_init_rec) else $error("init recovery");
	property p_init_done;
		$rose(pins.init_n) |-> ##[0:60] done;
	endproperty
	a_init_done: assert property (p_init_done) else $error("init end");
	property p_done;
		done |-> $past(busy);
	endproperty
	a_done: assert property (p_done) else $error("done alone");
endmodule
bind fhc_flash_host fhc_flash_host_sva u_sva (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
	.req_valid(req_valid), .req_write(req_write), .req_init(req_init), .pins(pins),
	.rvalid(rvalid), .done(done), .busy(busy));

// ---- sim/fhc_flash_model.sv ----
`timescale 1ns/10ps
module fhc_flash_model (
	input wire logic             clock,
	input fhc_pkg::fhc_pins_type pins,
	output logic [15:0]          dq_in,
	output logic                 ready_busy_n
);
	logic [7:0]  op_reg = 8'h00;
	logic [7:0]  rec_reg = 8'h00;
	logic        we_reg = 1'b1;
	logic [15:0] last_reg = 16'h0000;
	logic [15:0] arr;
	logic [20:0] addr_reg = 21'h0;
	logic [7:0]  still_reg = 8'h00;
	logic [15:0] held_reg = 16'h0000;
	logic        asleep;
	logic [15:0] word;
	assign arr = pins.addr[15:0] ^ 16'h3C3C;
	always_ff @(posedge clock)
	begin
		addr_reg <= pins.addr;
		if (pins.addr != addr_reg)
			still_reg <= 8'h00;
		else if (still_reg != 8'hFF)
			still_reg <= still_reg + 8'h01;
		if (!asleep)
			held_reg <= arr;
	end
	assign asleep = still_reg >= 8'h03;
	assign word = asleep ? held_reg : arr;
	always_ff @(posedge clock)
	begin
		we_reg <= pins.we_n;
		last_reg <= dq_in;
		if (!pins.init_n)
		begin
			rec_reg <= (op_reg != 8'h00 || rec_reg > 8'h02) ? 8'h0C : 8'h02;
			op_reg <= 8'h00;
		end
		else if (rec_reg != 8'h00)
			rec_reg <= rec_reg - 8'h01;
		else if (pins.we_n && !we_reg && !pins.sel_n)
			op_reg <= 8'h1E;
		else if (op_reg != 8'h00)
			op_reg <= op_reg - 8'h01;
	end
	assign ready_busy_n = (op_reg == 8'h00) && (rec_reg < 8'h03);
	always_comb
		if (pins.sel_n || pins.oe_n || !pins.init_n)
			dq_in = ~last_reg;
		else if (!ready_busy_n)
			dq_in = {~last_reg[15:8], 8'hA5};
		else
			dq_in = pins.byte_n ? word : {~last_reg[15:8], word[7:0]};
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	logic                  clock = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  clk_en = 1'b1;
	logic                  req_valid = 1'b0;
	logic                  req_write = 1'b0;
	logic                  req_init = 1'b0;
	logic                  req_byte_mode = 1'b0;
	logic [20:0]           req_addr = 21'h0;
	logic [15:0]           dq_in;
	logic                  ready_busy_n;
	fhc_pkg::fhc_pins_type pins;
	logic [15:0]           rdata;
	logic                  rvalid, done, busy, restart_needed;
	logic [5:0]            sector_index;
	int                    bad_count = 0;
	int                    total_checks = 0;
	fhc_flash_host #(.READY_BUSY_CYC(20)) dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
		.req_valid(req_valid), .req_write(req_write), .req_init(req_init),
		.req_byte_mode(req_byte_mode), .req_addr(req_addr), .req_wdata(16'h1234),
		.dq_in(dq_in), .ready_busy_n(ready_busy_n), .pins(pins), .rdata(rdata),
		.rvalid(rvalid), .done(done), .busy(busy), .sector_index(sector_index),
		.restart_needed(restart_needed));
	fhc_flash_model u_flash (.clock(clock), .pins(pins), .dq_in(dq_in),
		.ready_busy_n(ready_busy_n));
	initial
		forever #20 clock = ~clock;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic op(logic w, logic i, logic b, logic [20:0] a);
		@(negedge clock);
		{req_valid, req_write, req_init, req_byte_mode, req_addr} = {1'b1, w, i, b, a};
		@(negedge clock);
		req_valid = 1'b0;
		repeat (200)
		begin
			if (done === 1'b1)
				break;
			@(negedge clock);
		end
		chk(16'(done), 16'h1);
		chk(16'(rvalid), 16'(!w && !i));
	endtask
	task automatic t_map();
		logic [20:0] a [7] = '{21'h0, 21'h00FFFF, 21'h1EFFFF, 21'h1F7FFF, 21'h1F8000,
			21'h1FA000, 21'h1FFFFF};
		logic [5:0] s [7] = '{6'h00, 6'h00, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22};
		foreach (a[k])
		begin
			op(1'b0, 1'b0, 1'b1, a[k]);
			chk(16'(sector_index), 16'(s[k]));
			chk(rdata, {8'h00, a[k][7:0] ^ 8'h3C});
		end
		op(1'b0, 1'b0, 1'b0, 21'h000123);
		chk(rdata, 16'h3D1F);
	endtask
	task automatic t_busy();
		op(1'b1, 1'b0, 1'b0, 21'h10);
		chk(16'(ready_busy_n), 16'h0);
		op(1'b0, 1'b0, 1'b1, 21'h10);
		chk(rdata, 16'h00A5);
		op(1'b0, 1'b1, 1'b0, 21'h0);
		chk(16'(restart_needed), 16'h1);
		chk(16'(ready_busy_n), 16'h1);
		op(1'b1, 1'b0, 1'b0, 21'h10);
		chk(16'(restart_needed), 16'h0);
		repeat (100)
			if (!ready_busy_n)
				@(negedge clock);
		op(1'b0, 1'b1, 1'b0, 21'h0);
		chk(16'(restart_needed), 16'h0);
		op(1'b0, 1'b0, 1'b1, 21'h10);
		chk(rdata, 16'h002C);
	endtask
	initial
	begin
		#200000;
		bad_count++;
		finish_test();
	end
	initial
	begin
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		t_map();
		t_busy();
		finish_test();
	end
endmodule
